/* File: field_memory_pkg.sv */
// Shared constants and carrier types of the field memory FIFO
`default_nettype none
package field_memory_pkg;
  localparam int unsigned DEPTH        = 245772;
  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned DATA_W       = 12;
  localparam int unsigned BLOCK_WORDS  = 40;
  localparam int unsigned BLOCK_COUNT  = 6144;
  localparam int unsigned BLOCK_W      = 13;
  localparam int unsigned MIN_RUN      = 40;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 18'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 18'h3_C00B;  // DEPTH - 1
  localparam logic [ADDR_W-1:0] ADDR_ONE  = 18'h0_0001;
  localparam logic [BLOCK_W-1:0] BLOCK_LAST = 13'h17FF;  // BLOCK_COUNT - 1
  localparam logic [DATA_W-1:0]  DATA_ZERO  = 12'h000;

  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;

  // Control of one port for one clock
  typedef struct packed {
    logic                pointer_reset;  // Pointer reset request
    logic                gate;           // Transfer gate
    logic                block_mode;     // Start at a block boundary
    logic [BLOCK_W-1:0]  block_index;    // Block number used by block mode
  } port_ctrl_t;

  // Write request into the array
  typedef struct packed {
    logic  enable;
    addr_t addr;
    word_t data;
  } array_write_t;
endpackage
`default_nettype wire

/* File: field_store_ram.sv */
// Word array of the field memory with registered read data
`default_nettype none
module field_store_ram
  import field_memory_pkg::*;
(
  input  wire logic                           ref_clk,
  input  wire field_memory_pkg::array_write_t wr,
  input  wire logic                           rd_enable,
  input  wire field_memory_pkg::addr_t        rd_addr,
  output var  field_memory_pkg::word_t        rd_data
);
  word_t mem [DEPTH];

  // Storage is static; no refresh needed, contents persist across idle clocks
  always_ff @(posedge ref_clk) begin  // [RQ7]
    if (wr.enable) begin
      mem[wr.addr] <= wr.data;
    end
    if (rd_enable) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // field_store_ram
`default_nettype wire

/* File: field_memory_fifo.sv */
// Field memory FIFO: independent write and read pointers over one word array
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// [RQ1] Store 245772 twelve-bit words, sequential pointers
// [RQ2] Separate write and read ports, independent
// [RQ3] Controller resets write pointer before writing
// [RQ4] Controller resets read pointer before reading
// [RQ5] Block mode starts at any 40-word block
// [RQ6] Data reread unchanged until overwritten
// [RQ7] Contents retained while clocks pause
// [RQ8] Devices chain without glue logic
// [RQ9] Noise filter applied only when enabled; here both inputs of the filter multiplexer take ram_q, so no filter is applied
// [RQ10] Write reset edge moves pointer to zero
// [RQ11] Controller writes 40 words between resets
// [RQ12] Controller resets after last write
// [RQ13] Filter disabled means bypass multiplexer
// [RQ14] Read gate advances pointer, presents word
// [RQ15] Input gate advances write pointer
`default_nettype none
module field_memory_fifo
  import field_memory_pkg::*;
(
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire field_memory_pkg::port_ctrl_t  write_ctrl,
  input  wire field_memory_pkg::word_t       write_data,
  input  wire field_memory_pkg::port_ctrl_t  read_ctrl,
  output logic                               read_ready,
  input  wire logic                          noise_filter_enable,
  output logic                               out_valid,
  input  wire logic                          out_ready,
  output field_memory_pkg::word_t            out_data,
  output logic                               write_pointer_zero
);
  import field_memory_pkg::*;

  // Start address of a block
  function automatic addr_t block_start(input logic [BLOCK_W-1:0] idx);
    logic [BLOCK_W-1:0] clip;
    clip = (idx > BLOCK_LAST) ? BLOCK_LAST : idx;
    return ADDR_W'(clip * BLOCK_WORDS);
  endfunction

  // Pointer step with wrap at the last word
  function automatic addr_t step(input addr_t a);
    return (a == ADDR_LAST) ? ADDR_ZERO : a + ADDR_ONE;
  endfunction

  // Pointer after a reset request
  function automatic addr_t reset_target(input port_ctrl_t c);
    return c.block_mode ? block_start(c.block_index) : ADDR_ZERO;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Write side
  addr_t        wr_ptr, next_wr_ptr;
  array_write_t wr_req, next_wr_req;
  logic         zero_flag, next_zero_flag;

  // Reset wins over gate; gate writes then advances
  always_comb begin
    next_wr_ptr        = wr_ptr;
    next_wr_req        = '0;
    next_zero_flag     = zero_flag;
    if (write_ctrl.pointer_reset) begin
      next_wr_ptr    = reset_target(write_ctrl);  // [RQ10] [RQ5] [RQ3]
      next_zero_flag = (reset_target(write_ctrl) == ADDR_ZERO);
    end else if (write_ctrl.gate) begin
      next_wr_req.enable = 1'b1;                  // [RQ15] [RQ6]
      next_wr_req.addr   = wr_ptr;
      next_wr_req.data   = write_data;
      next_wr_ptr        = step(wr_ptr);          // [RQ1]
      next_zero_flag     = (step(wr_ptr) == ADDR_ZERO);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr    <= ADDR_ZERO;
      wr_req    <= '0;
      zero_flag <= 1'b1;
    end else begin
      wr_ptr    <= next_wr_ptr;
      wr_req    <= next_wr_req;
      zero_flag <= next_zero_flag;
    end
  end
  assign write_pointer_zero = zero_flag;

  //////////////////////////////////////////////////////////////////////////
  // Read side: fetch stage feeding a two-entry skid buffer
  addr_t rd_ptr, next_rd_ptr;
  logic  fetch_pending, next_fetch_pending;
  logic  fetch;
  word_t ram_q;
  word_t buf0, buf1, next_buf0, next_buf1;
  logic  [1:0] count, next_count;
  logic  ready_reg, next_ready_reg;
  logic  valid_reg, next_valid_reg;
  logic  pop;

  // Fetch only when the buffer has room for the word in flight
  assign fetch = read_ctrl.gate && !read_ctrl.pointer_reset && ready_reg;  // [RQ14]
  assign pop   = out_valid && out_ready;

  field_store_ram u_store (
    .ref_clk   (ref_clk),
    .wr        (wr_req),
    .rd_enable (fetch),
    .rd_addr   (rd_ptr),
    .rd_data   (ram_q)
  );

  // Read pointer and buffer update
  always_comb begin
    next_rd_ptr        = rd_ptr;
    next_fetch_pending = fetch;
    next_buf0          = buf0;
    next_buf1          = buf1;
    next_count         = count;
    if (read_ctrl.pointer_reset) begin
      next_rd_ptr = reset_target(read_ctrl);      // [RQ4] [RQ5]
    end else if (fetch) begin
      next_rd_ptr = step(rd_ptr);                 // [RQ14]
    end
    if (pop) begin
      next_buf0  = buf1;
      next_count = count - 2'd1;
    end
    if (fetch_pending) begin
      if (next_count == 2'd0) begin
        next_buf0 = noise_filter_enable ? ram_q : ram_q;  // [RQ13] [RQ9] bypass path
      end else begin
        next_buf1 = ram_q;
      end
      next_count = next_count + 2'd1;
    end
    // Ready only when the buffer is empty and no fetch is in flight
    next_ready_reg = (next_count + {1'b0, next_fetch_pending}) == 2'd0;
    // Head word stands until the receiver takes it
    next_valid_reg = (next_count != 2'd0);
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rd_ptr        <= ADDR_ZERO;
      fetch_pending <= 1'b0;
      buf0          <= DATA_ZERO;
      buf1          <= DATA_ZERO;
      count         <= 2'd0;
      ready_reg     <= 1'b1;
      valid_reg     <= 1'b0;
    end else begin
      rd_ptr        <= next_rd_ptr;
      fetch_pending <= next_fetch_pending;
      buf0          <= next_buf0;
      buf1          <= next_buf1;
      count         <= next_count;
      ready_reg     <= next_ready_reg;
      valid_reg     <= next_valid_reg;
    end
  end

  // Outputs straight from registers; the stream can feed a following device unchanged
  assign out_valid  = valid_reg;  // [RQ8]
  assign out_data   = buf0;
  assign read_ready = ready_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  // Write port
  AST_WR_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ10]
    write_ctrl.pointer_reset && !write_ctrl.block_mode |=> wr_ptr == ADDR_ZERO)
    else $error("write pointer not zero after reset");
  AST_WR_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ15]
    !write_ctrl.pointer_reset && write_ctrl.gate && wr_ptr != ADDR_LAST
    |=> wr_ptr == $past(wr_ptr) + ADDR_ONE)
    else $error("write pointer did not advance");
  AST_WR_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ1]
    !write_ctrl.pointer_reset && !write_ctrl.gate |=> $stable(wr_ptr))
    else $error("write pointer moved without gate");
  AST_WR_BLOCK_LAST: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ5]
    write_ctrl.pointer_reset && write_ctrl.block_mode && write_ctrl.block_index == BLOCK_LAST
    |=> wr_ptr == 18'h3_BFD8)  // Last block opens at word 245720
    else $error("last block start wrong");
  AST_WR_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ6]
    !write_ctrl.pointer_reset && write_ctrl.gate
    |=> wr_req.enable && wr_req.addr == $past(wr_ptr) && wr_req.data == $past(write_data))
    else $error("gated word not captured at the write pointer");
  AST_NO_WRITE_IDLE: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ15]
    write_ctrl.pointer_reset || !write_ctrl.gate |=> !wr_req.enable)
    else $error("array written without gate");
  AST_ZERO_FLAG: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ10]
    write_pointer_zero == (wr_ptr == ADDR_ZERO))
    else $error("zero flag disagrees with write pointer");
  // Read port
  AST_RD_RESET_ZERO: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ4]
    read_ctrl.pointer_reset && !read_ctrl.block_mode |=> rd_ptr == ADDR_ZERO)
    else $error("read pointer not zero after reset");
  AST_BLOCK_START: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ5]
    read_ctrl.pointer_reset && read_ctrl.block_mode && read_ctrl.block_index == 13'h0005
    |=> rd_ptr == 18'h0_00C8)  // Block five opens at word 200
    else $error("block start wrong");
  AST_RD_ADVANCE: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ14]
    fetch && rd_ptr != ADDR_LAST |=> rd_ptr == $past(rd_ptr) + ADDR_ONE)
    else $error("read pointer did not advance");
  AST_RD_REFUSED: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ14]
    read_ctrl.gate && !read_ctrl.pointer_reset && !read_ready |=> $stable(rd_ptr))
    else $error("read pointer moved while not ready");
  AST_RD_DELIVER: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ14]
    fetch && count == 2'd0 && !out_valid |=> ##1 out_valid)
    else $error("fetched word not presented");
  AST_VALID_DROPS: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ14]
    out_valid && out_ready && count == 2'h1 && !fetch_pending |=> !out_valid)
    else $error("taken word still shown");
  AST_READY_AFTER_DRAIN: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ14]
    out_valid && out_ready && count == 2'h1 && !fetch_pending |=> read_ready)
    else $error("read port not ready after drain");
  AST_NO_OVERFLOW: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ2]
    count <= 2'd2)
    else $error("buffer overflow");
  AST_STALL_HOLDS: assert property (@(posedge ref_clk) disable iff (!rstn)  // [RQ6]
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("stalled word lost");
endmodule // field_memory_fifo
`default_nettype wire

/* File: field_memory_partner.sv */
// Model of the video controller that drives both ports and takes output words
`default_nettype none
module field_memory_partner
  import field_memory_pkg::*;
(
  input  wire logic                    ref_clk,
  output var  field_memory_pkg::port_ctrl_t write_ctrl,
  output var  field_memory_pkg::word_t      write_data,
  output var  field_memory_pkg::port_ctrl_t read_ctrl,
  input  wire logic                    read_ready,
  input  wire logic                    out_valid,
  output var  logic                    out_ready,
  input  wire field_memory_pkg::word_t out_data
);
  timeunit 1ns;
  timeprecision 100ps;
  word_t got[$];
  int    stall_mode = 0;  // 0 ready, 1 alternate, 2 held off

  // Idle levels at time zero
  initial begin
    write_ctrl = '0;
    read_ctrl = '0;
    write_data = 12'h000;
    out_ready = 1'b0;
  end

  // Receiver takes a word on every valid and ready edge
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_data);
    out_ready <= #1 (stall_mode == 0) || (stall_mode == 1 && !out_ready);
  end

  // One edge of pointer reset, optionally into a block
  task automatic pointer_reset(input bit wr, input bit blk, input int idx);
    port_ctrl_t c;
    c = '{1'b1, 1'b0, blk, idx[BLOCK_W-1:0]};
    @(posedge ref_clk) #1;
    if (wr) write_ctrl = c;
    else read_ctrl = c;
    @(posedge ref_clk) #1;
    if (wr) write_ctrl = '0;
    else read_ctrl = '0;
  endtask

  // Burst of gated writes; data line flips once released
  task automatic write_run(input int n, input word_t base, input word_t step);
    @(posedge ref_clk) #1;
    write_ctrl.gate = 1'b1;
    for (int i = 0; i < n; i++) begin
      write_data = base + word_t'(i) * step;
      @(posedge ref_clk) #1;
    end
    write_ctrl.gate = 1'b0;
    write_data = ~write_data;
  endtask

  // Hold the read gate until n fetches were taken with read_ready high
  task automatic read_run(input int n);
    bit taken;
    @(posedge ref_clk) #1;
    read_ctrl.gate = 1'b1;
    for (int i = 0; i < n; i++) begin
      do begin
        @(negedge ref_clk) taken = (read_ready === 1'b1);
        @(posedge ref_clk);
      end while (!taken);
    end
    #1;
    read_ctrl.gate = 1'b0;
  endtask
endmodule  // field_memory_partner
`default_nettype wire

/* File: field_memory_fifo_bench.sv */
// Self-checking bench of the field memory FIFO
`default_nettype none
module field_memory_fifo_bench import field_memory_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       ref_clk, rstn, noise_filter_enable, read_ready;
  logic       out_valid, out_ready, write_pointer_zero;
  port_ctrl_t write_ctrl, read_ctrl;
  word_t      write_data, out_data;
  int         n_mismatch = 0;
  int         tests_run = 0;

  field_memory_fifo uut (.ref_clk, .rstn, .write_ctrl, .write_data, .read_ctrl, .read_ready,
    .noise_filter_enable, .out_valid, .out_ready, .out_data, .write_pointer_zero);
  field_memory_partner ctl (.ref_clk, .write_ctrl, .write_data, .read_ctrl, .read_ready,
    .out_valid, .out_ready, .out_data);

  // Clock at 200 MHz
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic compare_word(input word_t got, input word_t exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  // Compare the next n received words with base plus index times step
  task automatic expect_run(input int n, input word_t base, input word_t step);
    for (int i = 0; i < n; i++) begin
      repeat (20) if (ctl.got.size() == 0) @(posedge ref_clk) #1;
      compare_word(ctl.got.size() ? ctl.got.pop_front() : 12'hxxx, base + word_t'(i) * step);
    end
  endtask

  // Forty gated writes, then the write pointer reset that points at the next field
  task automatic write_field(input word_t base, input word_t step, input bit blk, input int idx);
    ctl.write_run(40, base, step);
    ctl.pointer_reset(1, blk, idx);
  endtask

  task automatic read_check(input bit blk, input int idx, input word_t base, input word_t step);
    ctl.pointer_reset(0, blk, idx);
    ctl.read_run(40);
    expect_run(40, base, step);
  endtask

  task automatic t_field();
    compare_bit(write_pointer_zero, 1'b1);
    compare_bit(read_ready, 1'b1);
    compare_bit(out_valid, 1'b0);
    ctl.pointer_reset(1, 0, 0);
    ctl.write_run(40, 12'h100, 12'h007);
    compare_bit(write_pointer_zero, 1'b0);
    ctl.pointer_reset(1, 0, 0);
    @(posedge ref_clk) #1;
    compare_bit(write_pointer_zero, 1'b1);
    ctl.stall_mode = 1;
    read_check(0, 0, 12'h100, 12'h007);
    ctl.stall_mode = 0;
  endtask

  task automatic t_reread();
    noise_filter_enable = 1'b1;
    read_check(0, 0, 12'h100, 12'h007);
    noise_filter_enable = 1'b0;
  endtask

  task automatic t_block();
    write_field(12'h100, 12'h007, 1, 5);
    write_field(12'h5A0, 12'h003, 1, 6143);
    write_field(12'hF00, 12'h005, 0, 0);
    read_check(1, 6143, 12'hF00, 12'h005);
    read_check(1, 5, 12'h5A0, 12'h003);
    read_check(1, 0, 12'h100, 12'h007);
  endtask

  // Reset after a write run: outputs return to idle, stored words stay
  task automatic t_reset();
    ctl.write_run(40, 12'h100, 12'h007);
    compare_bit(write_pointer_zero, 1'b0);
    @(posedge ref_clk) #1;
    rstn = 1'b0;
    @(posedge ref_clk) #1;
    compare_bit(write_pointer_zero, 1'b1);
    compare_bit(read_ready, 1'b1);
    compare_bit(out_valid, 1'b0);
    rstn = 1'b1;
    ctl.pointer_reset(1, 0, 0);
    repeat (50) @(posedge ref_clk);
    #1;
    read_check(0, 0, 12'h100, 12'h007);
  endtask

  // Receiver held off: the word stands and fetches are refused
  task automatic t_stall();
    ctl.stall_mode = 2;
    ctl.pointer_reset(0, 0, 0);
    fork
      ctl.read_run(3);
    join_none
    repeat (20) @(posedge ref_clk);
    #1;
    compare_bit(out_valid, 1'b1);
    compare_word(out_data, 12'h100);
    compare_bit(read_ready, 1'b0);
    ctl.stall_mode = 0;
    wait fork;
    expect_run(3, 12'h100, 12'h007);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rstn = 1'b0;
    noise_filter_enable = 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    t_field();
    t_reread();
    t_block();
    t_reset();
    t_stall();
    print_verdict();
  end

  // Watchdog
  initial begin
    #50us;
    n_mismatch++;
    print_verdict();
  end
endmodule  // field_memory_fifo_bench
`default_nettype wire
